// file: pkg/rtcie_pkg.sv
package rtcie_pkg;
	// Page 0 register offsets
	localparam logic [4:0] ADDR_MAIN_STATUS  = 5'h00;
	localparam logic [4:0] ADDR_PERIODIC     = 5'h03;
	localparam logic [4:0] ADDR_TEST_MODE    = 5'h1f;
	// Page 1 register offsets
	localparam logic [4:0] ADDR_RT_MODE      = 5'h01;
	localparam logic [4:0] ADDR_INT_CTRL_A   = 5'h03;
	localparam logic [4:0] ADDR_INT_CTRL_B   = 5'h04;
	// Main status register fields
	localparam int         BIT_PAGE_SEL      = 7;
	// Periodic flag register fields
	localparam int         BIT_TEST_MODE     = 7;
	localparam int         BIT_OSC_FAIL      = 6;
	// Real-time mode register fields
	localparam int         BIT_XTAL_HI       = 7;
	localparam int         BIT_XTAL_LO       = 6;
	localparam int         BIT_PF_HOLD       = 4;
	localparam int         BIT_CLK_RUN       = 3;
	// Interrupt control B fields
	localparam int         BIT_PF_ENABLE     = 7;
	// Crystal select codes
	localparam logic [1:0] XTAL_32K768       = 2'h0;
	localparam logic [1:0] XTAL_4M194        = 2'h1;
	localparam logic [1:0] XTAL_4M915        = 2'h2;
	localparam logic [1:0] XTAL_32K000       = 2'h3;
	localparam logic [7:0] RESET_BYTE        = 8'h00;
	// Host controller registers (AXI4-Lite byte addresses)
	localparam logic [3:0] HADDR_CTRL        = 4'h0;
	localparam logic [3:0] HADDR_STATUS      = 4'h4;
	localparam logic [3:0] HADDR_IRQ_STAT    = 4'h8;
	localparam logic [3:0] HADDR_IRQ_MASK    = 4'hc;
	localparam int         BIT_CTRL_START    = 0;
	localparam int         BIT_CTRL_SINGLE   = 1;
	localparam int         IRQ_DONE          = 0;
	localparam int         IRQ_FAULT         = 1;
	localparam logic [1:0] AXI_OKAY          = 2'h0;
	localparam logic [1:0] AXI_SLVERR        = 2'h2;
	// Start-up timing at 25 MHz
	localparam int         CLK_HZ            = 25000000;
	localparam int         RETRY_LIMIT_S     = 3;
	localparam int         RETRY_CYCLES      = RETRY_LIMIT_S * CLK_HZ;
	localparam int         POLL_GAP_US       = 100;
	localparam int         POLL_GAP_CYCLES   = POLL_GAP_US * (CLK_HZ / 1000000);
	localparam int         STROBE_CYCLES     = 2;
endpackage : rtcie_pkg

// file: pkg/rtcie_if.sv
`timescale 1ns/100ps
interface rtcie_if;
	logic       cs_n;
	logic       rd_n;
	logic       wr_n;
	logic [4:0] addr;
	logic [7:0] data_host;
	logic [7:0] data_dev;
	logic       data_dev_oe_n;
	logic       intr;
	logic       power_fail_input;
	wire  [7:0] data_bus = data_dev_oe_n ? data_host : data_dev;
	modport device (
		input  cs_n, rd_n, wr_n, addr, data_host, power_fail_input,
		output data_dev, data_dev_oe_n, intr
	);
	modport host (
		output cs_n, rd_n, wr_n, addr, data_host, power_fail_input,
		input  data_dev, data_dev_oe_n, intr
	);
endinterface : rtcie_if

// file: hw/rtcie_device.sv
`timescale 1ns/100ps
// Summary of operation
// RQ1 - Periodic flag D7 write enters/leaves test mode
// RQ2 - Host clears test register inside test mode
// RQ3 - Real-time mode D7:D6 pick crystal frequency
// RQ4 - Clock start bit sets only with oscillator running
// RQ5 - Host keeps crystal bits when starting clock
// RQ6 - Host retries start, polls fail flag every ~100us
// RQ7 - Host aborts after ~3s of failing flag
// RQ8 - Periodic flag D6 reads oscillator fail status
// RQ9 - Periodic flag D6 write selects supply mode
// RQ10 - Battery mode entered only if oscillator ok
// RQ11 - Control B D7 enables power fail input
// RQ12 - Mode D4 holds power fail enable in standby
// RQ13 - Control A bits 5:0 periodic enables, 7:6 RAM
// RQ14 - Control B bits power fail, alarm, compares
module rtcie_device (
	input  wire logic clk_sys,
	input  wire logic rst_n,
	rtcie_if.device   bus,
	input  wire logic osc_running,
	input  wire logic standby,
	output logic      test_mode,
	output logic      battery_mode,
	output logic      clock_running,
	output logic [1:0] xtal_select,
	output logic      power_fail_armed,
	output logic [5:0] periodic_enable,
	output logic [6:0] alarm_enable
);
	logic       page;
	logic [7:0] test_reg;
	logic [7:0] rt_mode;
	logic [7:0] ctrl_a;
	logic [7:0] ctrl_b;
	logic       power_fail_seen;
	logic       wr_q;
	logic       wr_edge;
	logic [7:0] rd_val;

	assign wr_edge = !bus.cs_n && !bus.wr_n && wr_q;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_q <= 1'b1;
		end else begin
			wr_q <= bus.cs_n || bus.wr_n;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			page     <= 1'b0;
			test_mode <= 1'b0;
			battery_mode <= 1'b0;
			test_reg <= rtcie_pkg::RESET_BYTE;
		end else if (wr_edge) begin
			if (bus.addr == rtcie_pkg::ADDR_MAIN_STATUS) begin
				page <= bus.data_host[rtcie_pkg::BIT_PAGE_SEL];
			end else if (!page && bus.addr == rtcie_pkg::ADDR_PERIODIC) begin
				test_mode <= bus.data_host[rtcie_pkg::BIT_TEST_MODE]; // RQ1
				if (bus.data_host[rtcie_pkg::BIT_OSC_FAIL]) begin
					battery_mode <= 1'b0; // RQ9
				end else if (osc_running) begin
					battery_mode <= 1'b1; // RQ10
				end
			end else if (!page && bus.addr == rtcie_pkg::ADDR_TEST_MODE && test_mode) begin
				test_reg <= bus.data_host; // RQ2
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rt_mode <= rtcie_pkg::RESET_BYTE;
			ctrl_a  <= rtcie_pkg::RESET_BYTE;
		end else if (wr_edge && page) begin
			if (bus.addr == rtcie_pkg::ADDR_RT_MODE) begin
				rt_mode <= bus.data_host;
				// Start bit cannot be set with a dead oscillator
				rt_mode[rtcie_pkg::BIT_CLK_RUN] <= bus.data_host[rtcie_pkg::BIT_CLK_RUN]
					&& osc_running; // RQ4
			end else if (bus.addr == rtcie_pkg::ADDR_INT_CTRL_A) begin
				ctrl_a <= bus.data_host; // RQ13
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_b <= rtcie_pkg::RESET_BYTE;
		end else if (wr_edge && page && bus.addr == rtcie_pkg::ADDR_INT_CTRL_B) begin
			ctrl_b <= bus.data_host; // RQ14
			if (standby && rt_mode[rtcie_pkg::BIT_PF_HOLD]) begin
				ctrl_b[rtcie_pkg::BIT_PF_ENABLE] <= 1'b1; // RQ12
			end
		end else if (standby && rt_mode[rtcie_pkg::BIT_PF_HOLD]) begin
			ctrl_b[rtcie_pkg::BIT_PF_ENABLE] <= ctrl_b[rtcie_pkg::BIT_PF_ENABLE]; // RQ12
		end else if (standby) begin
			ctrl_b[rtcie_pkg::BIT_PF_ENABLE] <= 1'b0;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			power_fail_seen <= 1'b0;
		end else if (!power_fail_armed) begin
			power_fail_seen <= 1'b0;
		end else if (!bus.power_fail_input) begin
			power_fail_seen <= 1'b1; // RQ11
		end
	end

	always_comb begin
		rd_val = rtcie_pkg::RESET_BYTE;
		if (bus.addr == rtcie_pkg::ADDR_MAIN_STATUS) begin
			rd_val[rtcie_pkg::BIT_PAGE_SEL] = page;
		end else if (!page && bus.addr == rtcie_pkg::ADDR_PERIODIC) begin
			rd_val[rtcie_pkg::BIT_TEST_MODE] = test_mode;
			rd_val[rtcie_pkg::BIT_OSC_FAIL]  = !osc_running; // RQ8
		end else if (!page && bus.addr == rtcie_pkg::ADDR_TEST_MODE) begin
			rd_val = test_reg;
		end else if (page && bus.addr == rtcie_pkg::ADDR_RT_MODE) begin
			rd_val = rt_mode;
		end else if (page && bus.addr == rtcie_pkg::ADDR_INT_CTRL_A) begin
			rd_val = ctrl_a;
		end else if (page && bus.addr == rtcie_pkg::ADDR_INT_CTRL_B) begin
			rd_val = ctrl_b;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			bus.data_dev <= rtcie_pkg::RESET_BYTE;
		end else begin
			bus.data_dev <= rd_val;
		end
	end

	assign bus.data_dev_oe_n = bus.cs_n || bus.rd_n;
	assign bus.intr         = power_fail_seen;
	assign xtal_select      = rt_mode[rtcie_pkg::BIT_XTAL_HI:rtcie_pkg::BIT_XTAL_LO]; // RQ3
	assign clock_running    = rt_mode[rtcie_pkg::BIT_CLK_RUN];
	assign power_fail_armed = ctrl_b[rtcie_pkg::BIT_PF_ENABLE]; // RQ11
	assign periodic_enable  = ctrl_a[5:0];
	assign alarm_enable     = ctrl_b[6:0];
endmodule : rtcie_device

// file: hw/rtcie_host.sv
`timescale 1ns/100ps
module rtcie_host #(
	parameter int RETRY_CYCLES = rtcie_pkg::RETRY_CYCLES
) (
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	rtcie_if.host            bus,
	input  wire logic        power_fail_level,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq
);
	typedef enum {
		RTCIE_IDLE, RTCIE_SEL0, RTCIE_TEST_ON, RTCIE_TEST_CLR, RTCIE_TEST_OFF, RTCIE_PAGE1,
		RTCIE_START, RTCIE_PAGE0, RTCIE_POLL, RTCIE_WAIT, RTCIE_SUPPLY, RTCIE_PAGE1B,
		RTCIE_ARM, RTCIE_HOLD, RTCIE_DONE, RTCIE_FAULT
	} rtcie_state_t;

	rtcie_state_t state;
	logic [1:0]   xtal;
	logic         single;
	logic [1:0]   irq_stat;
	logic [1:0]   irq_mask;
	logic         aw_got;
	logic         w_got;
	logic [3:0]   aw_addr;
	logic [31:0]  w_data;
	logic         wr_do;
	logic [31:0]  retry_cnt;
	logic [31:0]  gap_cnt;
	logic [1:0]   strobe_cnt;
	logic         reading;
	logic         ev_done;
	logic         ev_fault;
	logic         rd_stat;
	logic [31:0]  rd_word;

	assign wr_do = aw_got && w_got && !s_axi_bvalid;
	assign s_axi_awready = !aw_got;
	assign s_axi_wready  = !w_got;
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_stat = s_axi_arvalid && !s_axi_rvalid && s_axi_araddr == rtcie_pkg::HADDR_IRQ_STAT;
	assign ev_done  = state == RTCIE_HOLD && strobe_cnt == 2'd0;
	assign ev_fault = state == RTCIE_WAIT && retry_cnt >= RETRY_CYCLES - 1;
	assign irq = |(irq_stat & irq_mask);
	assign bus.power_fail_input = power_fail_level;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			s_axi_bvalid <= 1'b0;
			xtal <= rtcie_pkg::XTAL_32K768;
			single <= 1'b0;
			irq_mask <= 2'h0;
		end else begin
			if (s_axi_awvalid && !aw_got) begin
				aw_got <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_got) begin
				w_got <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_do) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Configuration is taken whenever no start-up sequence is running
				if (aw_addr == rtcie_pkg::HADDR_CTRL && s_axi_wstrb[0]
					&& (state == RTCIE_IDLE || state == RTCIE_DONE || state == RTCIE_FAULT)) begin
					single <= w_data[rtcie_pkg::BIT_CTRL_SINGLE];
					xtal <= w_data[3:2];
				end else if (aw_addr == rtcie_pkg::HADDR_IRQ_MASK && s_axi_wstrb[0]) begin
					irq_mask <= w_data[1:0];
				end
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	assign s_axi_bresp = rtcie_pkg::AXI_OKAY;

	always_comb begin
		rd_word = 32'h0;
		case (s_axi_araddr)
			rtcie_pkg::HADDR_CTRL:     rd_word = {28'h0, xtal, single, 1'b0};
			rtcie_pkg::HADDR_STATUS:   rd_word = {28'h0, state == RTCIE_FAULT,
				state == RTCIE_DONE, state != RTCIE_IDLE && state != RTCIE_DONE
				&& state != RTCIE_FAULT, 1'b0};
			rtcie_pkg::HADDR_IRQ_STAT: rd_word = {30'h0, irq_stat};
			rtcie_pkg::HADDR_IRQ_MASK: rd_word = {30'h0, irq_mask};
			default:                   rd_word = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= rtcie_pkg::AXI_OKAY;
		end else if (s_axi_arvalid && !s_axi_rvalid) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_word;
			s_axi_rresp <= s_axi_araddr[1:0] != 2'h0 || s_axi_araddr > rtcie_pkg::HADDR_IRQ_MASK
				? rtcie_pkg::AXI_SLVERR : rtcie_pkg::AXI_OKAY;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// Set beats read-clear
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat <= 2'h0;
		end else begin
			irq_stat[rtcie_pkg::IRQ_DONE]  <= ev_done  || (irq_stat[rtcie_pkg::IRQ_DONE] && !rd_stat);
			irq_stat[rtcie_pkg::IRQ_FAULT] <= ev_fault || (irq_stat[rtcie_pkg::IRQ_FAULT] && !rd_stat);
		end
	end

	// Retry budget counts clock cycles of the whole start-up sequence
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			retry_cnt <= 32'd0;
		end else if (state == RTCIE_IDLE || state == RTCIE_DONE || state == RTCIE_FAULT) begin
			retry_cnt <= 32'd0;
		end else begin
			retry_cnt <= retry_cnt + 32'd1; // RQ7
		end
	end

	// Bus cycle: each access holds strobe low for STROBE_CYCLES
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state <= RTCIE_IDLE;
			strobe_cnt <= 2'd0;
			gap_cnt <= 32'd0;
			reading <= 1'b0;
			bus.cs_n <= 1'b1;
			bus.wr_n <= 1'b1;
			bus.rd_n <= 1'b1;
			bus.addr <= 5'h0;
			bus.data_host <= 8'h0;
		end else if (strobe_cnt != 2'd0) begin
			strobe_cnt <= strobe_cnt - 2'd1;
			if (strobe_cnt == 2'd1) begin
				bus.cs_n <= 1'b1;
				bus.wr_n <= 1'b1;
				bus.rd_n <= 1'b1;
			end
		end else begin
			strobe_cnt <= 2'(rtcie_pkg::STROBE_CYCLES);
			bus.cs_n <= 1'b0;
			bus.wr_n <= 1'b0;
			case (state)
				RTCIE_IDLE: begin
					bus.cs_n <= 1'b1;
					bus.wr_n <= 1'b1;
					strobe_cnt <= 2'd0;
					if (wr_do && aw_addr == rtcie_pkg::HADDR_CTRL
						&& w_data[rtcie_pkg::BIT_CTRL_START]) begin
						state <= RTCIE_SEL0;
					end
				end
				// A restart after DONE finds page 1 selected; test mode lives on page 0
				RTCIE_SEL0: begin
					bus.addr <= rtcie_pkg::ADDR_MAIN_STATUS;
					bus.data_host <= 8'h00;
					gap_cnt <= 32'd0;
					state <= RTCIE_TEST_ON;
				end
				RTCIE_TEST_ON: begin
					bus.addr <= rtcie_pkg::ADDR_PERIODIC;
					bus.data_host <= 8'h80; // RQ2
					state <= RTCIE_TEST_CLR;
				end
				RTCIE_TEST_CLR: begin
					bus.addr <= rtcie_pkg::ADDR_TEST_MODE;
					bus.data_host <= rtcie_pkg::RESET_BYTE; // RQ2
					state <= RTCIE_TEST_OFF;
				end
				RTCIE_TEST_OFF: begin
					bus.addr <= rtcie_pkg::ADDR_PERIODIC;
					bus.data_host <= 8'h40;
					state <= RTCIE_PAGE1;
				end
				RTCIE_PAGE1: begin
					bus.addr <= rtcie_pkg::ADDR_MAIN_STATUS;
					bus.data_host <= 8'h80;
					state <= RTCIE_START;
				end
				RTCIE_START: begin
					bus.addr <= rtcie_pkg::ADDR_RT_MODE;
					bus.data_host <= {xtal, 6'h08}; // RQ5
					state <= RTCIE_PAGE0;
				end
				RTCIE_PAGE0: begin
					bus.addr <= rtcie_pkg::ADDR_MAIN_STATUS;
					bus.data_host <= 8'h00;
					state <= RTCIE_POLL;
				end
				RTCIE_POLL: begin
					bus.wr_n <= 1'b1;
					bus.rd_n <= 1'b0;
					bus.addr <= rtcie_pkg::ADDR_PERIODIC;
					reading <= 1'b1;
					state <= RTCIE_WAIT;
				end
				RTCIE_WAIT: begin
					bus.cs_n <= 1'b1;
					bus.wr_n <= 1'b1;
					reading <= 1'b0;
					// Waiting runs every cycle, not once per bus cycle
					strobe_cnt <= 2'd0;
					if (reading && !bus.data_dev[rtcie_pkg::BIT_OSC_FAIL]) begin
						state <= RTCIE_SUPPLY; // RQ6
					end else if (ev_fault) begin
						state <= RTCIE_FAULT; // RQ7
					end else if (gap_cnt >= rtcie_pkg::POLL_GAP_CYCLES) begin
						gap_cnt <= 32'd0;
						state <= RTCIE_PAGE1; // RQ6
					end else begin
						gap_cnt <= gap_cnt + 32'd1;
					end
				end
				RTCIE_SUPPLY: begin
					bus.addr <= rtcie_pkg::ADDR_PERIODIC;
					bus.data_host <= {1'b0, single, 6'h00};
					state <= RTCIE_PAGE1B;
				end
				RTCIE_PAGE1B: begin
					bus.addr <= rtcie_pkg::ADDR_MAIN_STATUS;
					bus.data_host <= 8'h80;
					state <= RTCIE_ARM;
				end
				RTCIE_ARM: begin
					bus.addr <= rtcie_pkg::ADDR_INT_CTRL_B;
					bus.data_host <= 8'h80;
					state <= RTCIE_HOLD;
				end
				RTCIE_HOLD: begin
					bus.addr <= rtcie_pkg::ADDR_RT_MODE;
					bus.data_host <= {xtal, 6'h18};
					state <= RTCIE_DONE;
				end
				RTCIE_DONE, RTCIE_FAULT: begin
					bus.cs_n <= 1'b1;
					bus.wr_n <= 1'b1;
					strobe_cnt <= 2'd0;
					if (wr_do && aw_addr == rtcie_pkg::HADDR_CTRL
						&& w_data[rtcie_pkg::BIT_CTRL_START]) begin
						state <= RTCIE_SEL0;
					end
				end
				default: state <= RTCIE_IDLE;
			endcase
		end
	end
endmodule : rtcie_host

// file: tb/rtcie_chk.sv
`timescale 1ns/100ps
module rtcie_chk (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       cs_n,
	input wire logic       rd_n,
	input wire logic       wr_n,
	input wire logic [4:0] addr,
	input wire logic [7:0] data_host,
	input wire logic       data_dev_oe_n
);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);
	sequence wr_start;
		$fell(wr_n) && !cs_n;
	endsequence
	sequence test_on;
		$fell(wr_n) && addr == rtcie_pkg::ADDR_PERIODIC && data_host[rtcie_pkg::BIT_TEST_MODE];
	endsequence
	sequence test_clear;
		$fell(wr_n) && addr == rtcie_pkg::ADDR_TEST_MODE;
	endsequence
	a_oe_on_read: assert property ((!cs_n && !rd_n) |-> !data_dev_oe_n)
		else $error("Device not driving during read");
	a_oe_off_idle: assert property ((cs_n || rd_n) |-> data_dev_oe_n)
		else $error("Device driving outside read");
	a_no_rd_wr: assert property (!(!rd_n && !wr_n))
		else $error("Read and write strobes together");
	a_wr_strobe_len: assert property (wr_start |=> !wr_n ##1 wr_n)
		else $error("Write strobe length wrong");
	a_rd_strobe_len: assert property ($fell(rd_n) |=> !rd_n ##1 rd_n)
		else $error("Read strobe length wrong");
	a_wr_hold: assert property ((!wr_n && !$fell(wr_n)) |-> $stable(addr) && $stable(data_host))
		else $error("Write address or data moved");
	a_test_clear_zero: assert property (test_clear |-> data_host == 8'h00)
		else $error("Test register not cleared to zero");
	a_test_then_clear: assert property (test_on |-> ##[1:12] test_clear)
		else $error("Test register not cleared after test entry");
endmodule : rtcie_chk

// file: tb/rtcie_interrupt_enable_test.sv
`timescale 1ns/100ps
module rtcie_interrupt_enable_test;
	logic        clk_sys = 1'b0;
	logic        rst_n = 1'b0;
	logic        osc_running = 1'b0;
	logic        standby = 1'b0;
	logic        power_fail_level = 1'b1;
	logic [3:0]  awaddr = 4'h0;
	logic        awvalid = 1'b0;
	logic [31:0] wdata = 32'h0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic [3:0]  araddr = 4'h0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid, irq;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        test_mode, battery_mode, clock_running, power_fail_armed;
	logic [1:0]  xtal_select;
	logic [5:0]  periodic_enable;
	logic [6:0]  alarm_enable;
	int          errors = 0;
	int          num_checks = 0;
	int          seed = 4;
	int          model_irq = 0;
	logic [31:0] rd_val;
	logic [1:0]  rd_resp;
	rtcie_if bus_if ();
	always #20 clk_sys = ~clk_sys;
	rtcie_device rtcie_device_inst (.clk_sys(clk_sys), .rst_n(rst_n), .bus(bus_if.device),
		.osc_running(osc_running), .standby(standby), .test_mode(test_mode),
		.battery_mode(battery_mode), .clock_running(clock_running), .xtal_select(xtal_select),
		.power_fail_armed(power_fail_armed), .periodic_enable(periodic_enable),
		.alarm_enable(alarm_enable));
	rtcie_host #(.RETRY_CYCLES(6000)) rtcie_host_inst (.clk_sys(clk_sys), .rst_n(rst_n),
		.bus(bus_if.host), .power_fail_level(power_fail_level), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .irq(irq));
	rtcie_chk chk_inst (.clk_sys(clk_sys), .rst_n(rst_n), .cs_n(bus_if.cs_n),
		.rd_n(bus_if.rd_n), .wr_n(bus_if.wr_n), .addr(bus_if.addr),
		.data_host(bus_if.data_host), .data_dev_oe_n(bus_if.data_dev_oe_n));
	task automatic complete_run;
		if (errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : complete_run
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic timed_out;
		errors++;
		$display("MISMATCH t=%0t wait ran out", $time);
		complete_run();
	endtask : timed_out
	task automatic axi_write(input logic [3:0] a, input logic [31:0] d);
		int n;
		@(posedge clk_sys);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_sys);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
			if (bvalid) break;
		end
		if (n == 200) timed_out();
		rd_resp = bresp;
		bready <= 1'b0;
	endtask : axi_write
	task automatic axi_read(input logic [3:0] a);
		int n;
		@(posedge clk_sys);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clk_sys);
			if (arvalid && arready) arvalid <= 1'b0;
			if (rvalid) break;
		end
		if (n == 200) timed_out();
		rd_val = rdata;
		rd_resp = rresp;
		rready <= 1'b0;
	endtask : axi_read
	task automatic read_irq_stat;
		axi_read(rtcie_pkg::HADDR_IRQ_STAT);
		check(rd_val, model_irq);
		model_irq = 0;
		axi_read(rtcie_pkg::HADDR_IRQ_STAT);
		check(rd_val, 32'h0);
		check(irq, 1'b0);
	endtask : read_irq_stat
	initial begin
		int n;
		int k;
		logic [1:0] code;
		repeat (10) @(posedge clk_sys);
		rst_n <= 1'b1;
		axi_read(4'h2);
		check(rd_resp, rtcie_pkg::AXI_SLVERR);
		axi_write(rtcie_pkg::HADDR_IRQ_MASK, 32'h0);
		code = 2'($random(seed));
		axi_write(rtcie_pkg::HADDR_CTRL, {28'h0, code, 2'b01});
		for (n = 0; n < 3000; n++) begin
			axi_read(rtcie_pkg::HADDR_STATUS);
			if (rd_val[3]) break;
		end
		if (n == 3000) timed_out();
		model_irq = 2;
		check(irq, 1'b0);
		check(clock_running, 1'b0);
		check(battery_mode, 1'b0);
		axi_write(rtcie_pkg::HADDR_IRQ_MASK, 32'h3);
		repeat (2) @(posedge clk_sys);
		check(irq, 1'b1);
		read_irq_stat();
		fork
			begin
				repeat (1000) @(posedge clk_sys);
				osc_running <= 1'b1;
			end
		join_none
		for (k = 0; k < 4; k++) begin
			code = 2'(k);
			axi_write(rtcie_pkg::HADDR_CTRL, {28'h0, code, k[0], 1'b1});
			for (n = 0; n < 20000; n++) begin
				@(posedge clk_sys);
				if (irq === 1'b1) break;
			end
			if (n == 20000) timed_out();
			model_irq = 1;
			read_irq_stat();
			check(xtal_select, code);
			check(clock_running, 1'b1);
			check(battery_mode, !k[0]);
			check(test_mode, 1'b0);
			check(power_fail_armed, 1'b1);
			check(alarm_enable, 7'h00);
			check(periodic_enable, 6'h00);
		end
		standby <= 1'b1;
		repeat (10) @(posedge clk_sys);
		check(power_fail_armed, 1'b1);
		standby <= 1'b0;
		power_fail_level <= 1'b0;
		for (n = 0; n < 20; n++) begin
			@(posedge clk_sys);
			if (bus_if.intr === 1'b1) break;
		end
		check(bus_if.intr, 1'b1);
		complete_run();
	end
endmodule : rtcie_interrupt_enable_test
